//--- pst_top.sv
// RAM enables, write hold latch, framing and tick divider, switch scan.
// Assumes processor pins arrive asynchronously and are resynchronised.
//
// Overview of operation
// - RAM select: low 2K, or paged 8000-9FFF
// - Write drives write and chip select low
// - Read drives output enable low
// - Decode only while phase clock high
// - Write low keeps delay reset, latch transparent
// - Phase clock fall captures write data
// - Next phase rise after write sets delay
// - Delay high floats the write latch
// - Framing clock divides by 512, 1024, 2048
// - Ratios: television, two-line, four-line readout
// - Each framing period loads next subframe
// - Active-low tick every 8192 phase clocks
// - Clear bit high holds divider cleared
// - Row data loaded as two bytes
// - Column select steers column to status
// - Status buffer drives only when enabled
// - Two output registers for panel hardware
`timescale 1ns/1ps
module pst_top (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Processor bus pins
  input wire pst_pkg::pst_cpu_s cpu_i,
  // Buffered data bus, write latch side
  output logic [7:0] wlat_data_o,
  output logic wlat_oe_n_o,
  // RAM enables
  output pst_pkg::pst_ram_s ram_o,
  // Status buffer
  input wire logic status_en_n_i,
  output logic [7:0] status_data_o,
  output logic status_oe_n_o,
  // Switch matrix
  output logic [9:0] row_n_o,
  input wire logic [7:0] column_i,
  // Panel hardware controls
  output logic [2:0] pot_sel_o,
  output logic ram_page_bit_0_o,
  output logic ram_page_bit_1_o,
  output logic ram_page_bit_2_o,
  output logic pwr_dn_o,
  output logic [2:0] pot_mux_en_o,
  output logic trig_led_o,
  output logic ser_data_o,
  output logic atten_stb_o,
  // Readout and processor interrupt
  output logic frame_clk_o,
  output logic subframe_load_o,
  output logic irq_n_o,
  // Register port
  input wire logic [pst_pkg::REG_AW-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o
);
  import pst_pkg::*;

  // RAM window test, used for both address ranges
  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Synchronisers reset to idle pins; zero would fake a write
  localparam int unsigned SYNC_W = $bits(pst_cpu_s) + 1 + 8;
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {24'h000000, 3'b101, 8'hFF};
  logic [SYNC_W-1:0] meta_ff;
  logic [SYNC_W-1:0] sync_ff;
  pst_cpu_s cpu_s;
  logic status_en_n_s;
  logic [7:0] column_s;

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      meta_ff <= SYNC_IDLE;
      sync_ff <= SYNC_IDLE;
    end
    else
    begin
      meta_ff <= {cpu_i, status_en_n_i, column_i};
      sync_ff <= meta_ff;
    end
  end

  assign cpu_s = sync_ff[SYNC_W-1 -: $bits(pst_cpu_s)];
  assign status_en_n_s = sync_ff[8];
  assign column_s = sync_ff[7:0];

  // Phase clock edges
  logic phase_d_ff;
  logic phase_rise;
  logic phase_fall;

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      phase_d_ff <= 1'b0;
    else
      phase_d_ff <= cpu_s.phase;
  end

  assign phase_rise = cpu_s.phase && !phase_d_ff;
  assign phase_fall = !cpu_s.phase && phase_d_ff;

  // Software registers
  logic [7:0] row_lo_ff;
  logic [7:0] row_hi_ff;
  logic [7:0] out_a_ff;
  logic [7:0] out_b_ff;
  logic wr_row_lo;
  logic wr_row_hi;
  logic wr_out_a;
  logic wr_out_b;

  assign wr_row_lo = reg_wr_i && (reg_addr_i == REG_ROW_LO);
  assign wr_row_hi = reg_wr_i && (reg_addr_i == REG_ROW_HI);
  assign wr_out_a = reg_wr_i && (reg_addr_i == REG_OUT_A);
  assign wr_out_b = reg_wr_i && (reg_addr_i == REG_OUT_B);

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      row_lo_ff <= ROW_LO_RST;
      row_hi_ff <= ROW_HI_RST;
      out_a_ff <= OUT_A_RST;
      out_b_ff <= OUT_B_RST;
    end
    else
    begin
      if (wr_row_lo)
        row_lo_ff <= reg_wdata_i;
      if (wr_row_hi)
        row_hi_ff <= reg_wdata_i;
      if (wr_out_a)
        out_a_ff <= reg_wdata_i;
      if (wr_out_b)
        out_b_ff <= reg_wdata_i;
    end
  end

  // Panel outputs; rows idle high, one row low is firmware's job
  assign row_n_o = {row_hi_ff[ROW_HI_ROWS_LSB +: 2], row_lo_ff};
  assign pot_sel_o = out_a_ff[POT_SEL_LSB +: 3];
  assign ram_page_bit_0_o = out_a_ff[PAGE_LSB];
  assign ram_page_bit_1_o = out_a_ff[PAGE_LSB+1];
  assign ram_page_bit_2_o = out_a_ff[PAGE_LSB+2];
  assign pwr_dn_o = out_a_ff[PWR_DN_BIT];
  assign pot_mux_en_o = out_b_ff[MUX_EN_LSB +: 3];
  assign trig_led_o = out_b_ff[TRIG_LED_BIT];
  assign ser_data_o = out_b_ff[SER_DATA_BIT];
  assign atten_stb_o = out_b_ff[ATTEN_STB_BIT];

  // RAM decode, valid only in the settled half of the cycle
  logic any_page;
  logic ram_hit;
  logic ram_sel;
  pst_ram_s nxt_ram;
  pst_ram_s ram_ff;

  assign any_page = |out_a_ff[PAGE_LSB +: 3];
  assign ram_hit = in_range(cpu_s.addr, 16'h0000, RAM_LOW_TOP) ||
                   (any_page &&
                    in_range(cpu_s.addr, RAM_PAGE_BASE, RAM_PAGE_TOP));
  assign ram_sel = ram_hit && cpu_s.phase;
  assign nxt_ram.cs_n = !ram_sel;
  assign nxt_ram.we_n = !(ram_sel && !cpu_s.rw);
  assign nxt_ram.oe_n = !(ram_sel && cpu_s.rw);

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      ram_ff <= '1;
    else
      ram_ff <= nxt_ram;
  end

  assign ram_o = ram_ff;

  // Write hold latch with delay flop; the half-cycle of extra drive
  // covers the RAM data hold time after the write strobe ends
  logic dly_ff;
  logic nxt_dly;
  logic [7:0] wlat_ff;
  logic [7:0] nxt_wlat;

  always_comb
  begin
    nxt_dly = dly_ff;
    if (!cpu_s.rw)
      nxt_dly = 1'b0;
    else if (phase_rise)
      nxt_dly = 1'b1;
  end

  always_comb
  begin
    nxt_wlat = wlat_ff;
    if (!cpu_s.rw)
      nxt_wlat = cpu_s.data;
    else if (phase_fall && !dly_ff)
      nxt_wlat = cpu_s.data;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      dly_ff <= 1'b1;
      wlat_ff <= 8'h00;
    end
    else
    begin
      dly_ff <= nxt_dly;
      wlat_ff <= nxt_wlat;
    end
  end

  assign wlat_data_o = wlat_ff;
  assign wlat_oe_n_o = dly_ff;

  // Framing and tick divider, advanced on each phase clock rise
  logic [DIV_W-1:0] div_cnt;
  logic cnt_clr;

  assign cnt_clr = row_hi_ff[CNT_CLR_BIT];

  pst_divider #(
    .WIDTH(DIV_W)
  ) i_pst_divider (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .adv_i(phase_rise),
    .clr_i(cnt_clr),
    .count_o(div_cnt)
  );

  // Frame ratio select: each tap is a square wave
  logic [1:0] frame_sel;
  logic nxt_frame;
  logic frame_ff;
  logic irq_n_ff;

  assign frame_sel = out_b_ff[FRAME_SEL_LSB +: 2];

  always_comb
  begin
    case (frame_sel)
      PST_FRAME_TV: nxt_frame = div_cnt[TAP_TV-1];
      PST_FRAME_2LINE: nxt_frame = div_cnt[TAP_2LINE-1];
      PST_FRAME_4LINE: nxt_frame = div_cnt[TAP_4LINE-1];
      default: nxt_frame = div_cnt[TAP_4LINE-1];
    endcase
  end

  // Tick is low while divider bit 12 is set, so it releases by itself on wrap or when firmware clears the divider
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      frame_ff <= 1'b0;
      irq_n_ff <= 1'b1;
    end
    else
    begin
      frame_ff <= nxt_frame;
      irq_n_ff <= !div_cnt[TAP_IRQ-1];
    end
  end

  assign frame_clk_o = frame_ff;
  assign subframe_load_o = nxt_frame && !frame_ff;
  assign irq_n_o = irq_n_ff;

  // Column selector and power-up jumper capture
  logic [2:0] col_sel;
  logic col_level;
  logic cal_done_ff;
  logic cal_ok_ff;
  logic cal_deny_ff;

  assign col_sel = row_hi_ff[COL_SEL_LSB +: 3];
  assign col_level = column_s[col_sel];

  // Taken a few cycles after reset, once the synchroniser is filled;
  // later jumper moves are ignored until the next reset
  logic [1:0] cal_wait_ff;

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      cal_wait_ff <= 2'b00;
      cal_done_ff <= 1'b0;
      cal_ok_ff <= 1'b0;
      cal_deny_ff <= 1'b0;
    end
    else if (!cal_done_ff)
    begin
      cal_wait_ff <= cal_wait_ff + 2'b01;
      if (cal_wait_ff == 2'b11)
      begin
        cal_done_ff <= 1'b1;
        cal_ok_ff <= !column_s[CAL_OK_COL];
        cal_deny_ff <= !column_s[CAL_DENY_COL];
      end
    end
  end

  // Status byte
  logic [7:0] status_byte;
  logic [7:0] status_ff;

  always_comb
  begin
    status_byte = 8'h00;
    status_byte[ST_COLUMN_BIT] = col_level;
    status_byte[ST_CAL_OK_BIT] = cal_ok_ff;
    status_byte[ST_CAL_DENY_BIT] = cal_deny_ff;
    status_byte[ST_FRAME_BIT] = frame_ff;
    status_byte[ST_IRQ_N_BIT] = irq_n_ff;
  end

  logic st_drive_ff;

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      status_ff <= 8'h00;
      st_drive_ff <= 1'b0;
    end
    else
    begin
      status_ff <= status_byte;
      st_drive_ff <= !status_en_n_s && cpu_s.phase;
    end
  end

  assign status_data_o = status_ff;
  assign status_oe_n_o = !st_drive_ff;

  // Register read path, answer in the next cycle only
  logic [7:0] rd_mux;
  logic [7:0] rdata_ff;

  always_comb
  begin
    case (reg_addr_i)
      REG_ROW_LO: rd_mux = row_lo_ff;
      REG_ROW_HI: rd_mux = row_hi_ff;
      REG_OUT_A: rd_mux = out_a_ff;
      REG_OUT_B: rd_mux = out_b_ff;
      REG_STATUS: rd_mux = status_byte;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      rdata_ff <= 8'h00;
    else if (reg_rd_i)
      rdata_ff <= rd_mux;
    else
      rdata_ff <= 8'h00;
  end

  assign reg_rdata_o = rdata_ff;

endmodule // pst_top

//--- pst_pkg.sv
// Package for the processor support, timing and switch scan block.
// Assumes one 50 MHz clock and a plain 8-bit register port.
package pst_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned PHASE_HZ = 1_250_000;
  localparam int unsigned IRQ_PERIOD_US = 3300;
  localparam int unsigned DIV_W = 13;
  // Tap positions counted from one, as the divider is described
  localparam int unsigned TAP_TV = 9;
  localparam int unsigned TAP_2LINE = 10;
  localparam int unsigned TAP_4LINE = 11;
  localparam int unsigned TAP_IRQ = 13;

  // Processor address map
  localparam logic [15:0] RAM_LOW_TOP = 16'h07FF;
  localparam logic [15:0] RAM_PAGE_BASE = 16'h8000;
  localparam logic [15:0] RAM_PAGE_TOP = 16'h9FFF;

  // Register port
  localparam int unsigned REG_AW = 3;
  localparam logic [2:0] REG_ROW_LO = 3'h0;
  localparam logic [2:0] REG_ROW_HI = 3'h1;
  localparam logic [2:0] REG_OUT_A = 3'h2;
  localparam logic [2:0] REG_OUT_B = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;

  // Field positions of REG_ROW_HI
  localparam int unsigned ROW_HI_ROWS_LSB = 0;
  localparam int unsigned COL_SEL_LSB = 2;
  localparam int unsigned CNT_CLR_BIT = 5;
  // Field positions of REG_OUT_A
  localparam int unsigned POT_SEL_LSB = 0;
  localparam int unsigned PAGE_LSB = 3;
  localparam int unsigned PWR_DN_BIT = 6;
  // Field positions of REG_OUT_B
  localparam int unsigned MUX_EN_LSB = 0;
  localparam int unsigned TRIG_LED_BIT = 3;
  localparam int unsigned SER_DATA_BIT = 4;
  localparam int unsigned ATTEN_STB_BIT = 5;
  localparam int unsigned FRAME_SEL_LSB = 6;
  // Field positions of REG_STATUS
  localparam int unsigned ST_COLUMN_BIT = 0;
  localparam int unsigned ST_CAL_OK_BIT = 1;
  localparam int unsigned ST_CAL_DENY_BIT = 2;
  localparam int unsigned ST_FRAME_BIT = 3;
  localparam int unsigned ST_IRQ_N_BIT = 4;

  // Reset values
  localparam logic [7:0] ROW_LO_RST = 8'hFF;
  localparam logic [7:0] ROW_HI_RST = 8'h03;
  localparam logic [7:0] OUT_A_RST = 8'h00;
  localparam logic [7:0] OUT_B_RST = 8'h00;

  // Column selector inputs used by the calibration jumper
  localparam int unsigned CAL_OK_COL = 5;
  localparam int unsigned CAL_DENY_COL = 6;

  typedef enum logic [1:0] {
    PST_FRAME_TV = 2'b00,
    PST_FRAME_2LINE = 2'b01,
    PST_FRAME_4LINE = 2'b11
  } pst_frame_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic rw;
    logic phase;
  } pst_cpu_s;

  typedef struct packed {
    logic cs_n;
    logic we_n;
    logic oe_n;
  } pst_ram_s;

endpackage

//--- pst_divider.sv
// Phase-clock divider for readout framing and the real-time tick.
// Assumes a one-cycle advance enable and a held synchronous clear.
`timescale 1ns/1ps
module pst_divider #(
  parameter int unsigned WIDTH = pst_pkg::DIV_W
)
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic adv_i,
  input wire logic clr_i,
  // Count
  output logic [WIDTH-1:0] count_o
);
  import pst_pkg::*;

  logic [WIDTH-1:0] cnt_ff;
  logic [WIDTH-1:0] nxt_cnt;

  assign nxt_cnt = clr_i ? '0 : (adv_i ? cnt_ff + 1'b1 : cnt_ff);
  assign count_o = cnt_ff;

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end

endmodule // pst_divider

//--- pst_top_props.sv
// Port checker for the processor support block.
// Assumes pins pass two sync flops and one register stage.
`timescale 1ns/1ps
module pst_top_props (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Watched ports
  input wire pst_pkg::pst_cpu_s cpu_i,
  input wire logic wlat_oe_n_o,
  input wire pst_pkg::pst_ram_s ram_o,
  input wire logic status_en_n_i,
  input wire logic status_oe_n_o,
  input wire logic ram_page_bit_0_o,
  input wire logic ram_page_bit_1_o,
  input wire logic ram_page_bit_2_o,
  input wire logic frame_clk_o,
  input wire logic subframe_load_o,
  input wire logic irq_n_o,
  input wire logic [pst_pkg::REG_AW-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i
);
  import pst_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic clr_ff;
  wire pg = ram_page_bit_0_o | ram_page_bit_1_o | ram_page_bit_2_o;
  wire ram_ok = cpu_i.addr <= RAM_LOW_TOP || (cpu_i.addr >= RAM_PAGE_BASE
    && cpu_i.addr <= RAM_PAGE_TOP && pg);
  // Shadow of the divider clear bit, seen from the register port
  always_ff @(posedge mclk_i)
    if (!rst_n_i)
      clr_ff <= 1'b0;
    else if (reg_wr_i && reg_addr_i == REG_ROW_HI)
      clr_ff <= reg_wdata_i[CNT_CLR_BIT];
  a_ram_window: assert property (!ram_o.cs_n |->
    $past(ram_ok, 3) && $past(cpu_i.phase, 3)) else $error("ram window");
  a_ram_write: assert property (!ram_o.we_n |->
    !ram_o.cs_n && ram_o.oe_n) else $error("ram write enables");
  a_ram_read: assert property (!ram_o.oe_n |->
    !ram_o.cs_n && ram_o.we_n) else $error("ram read enables");
  a_latch_open: assert property (!$past(cpu_i.rw, 3) |->
    !wlat_oe_n_o) else $error("latch off in write");
  a_latch_hold: assert property ($rose(wlat_oe_n_o) |->
    $past(cpu_i.rw, 3) && $past(cpu_i.phase, 3)) else $error("latch off");
  a_load_pulse: assert property (subframe_load_o |=>
    $rose(frame_clk_o)) else $error("load without frame edge");
  a_frame_cause: assert property ($rose(frame_clk_o) |->
    $past(subframe_load_o)) else $error("frame edge without load");
  a_clear_hold: assert property (clr_ff && $past(clr_ff, 3) |->
    irq_n_o && !frame_clk_o) else $error("divider not held");
  a_status_drive: assert property (!status_oe_n_o |->
    $past(!status_en_n_i && cpu_i.phase, 3)) else $error("status drive");
  c_ram_write: cover property (!ram_o.we_n);
  c_tick: cover property ($fell(irq_n_o));
  c_status: cover property (!status_oe_n_o);
endmodule // pst_top_props

bind pst_top pst_top_props i_pst_top_props (.mclk_i, .rst_n_i, .cpu_i,
  .wlat_oe_n_o, .ram_o, .status_en_n_i, .status_oe_n_o, .ram_page_bit_0_o,
  .ram_page_bit_1_o, .ram_page_bit_2_o, .frame_clk_o, .subframe_load_o,
  .irq_n_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i);

//--- pst_cpu_model.sv
// Processor bus and front-panel switch matrix model.
// Assumes one bus cycle at a time, called by the bench.
`timescale 1ns/1ps
module pst_cpu_model (
  // Clock
  input wire logic mclk_i,
  // Panel rows
  input wire logic [9:0] row_n_i,
  // Processor pins and panel columns
  output pst_pkg::pst_cpu_s cpu_o,
  output logic [7:0] column_o
);
  import pst_pkg::*;
  int half = 20;
  int cnt = 0;
  initial cpu_o = '{16'h1000, 8'h00, 1'b1, 1'b0};
  // Half period may be cut to keep long divider counts short
  always @(posedge mclk_i)
  begin
    cnt <= (cnt >= half - 1) ? 0 : cnt + 1;
    if (cnt >= half - 1)
      cpu_o.phase <= ~cpu_o.phase;
  end
  // Cycle runs fall to fall; rw and data outlive the fall by one clock
  task automatic cycle(input logic rw, input logic [15:0] a,
    input logic [7:0] v);
    @(posedge mclk_i iff (cpu_o.phase && cnt >= half - 1));
    cpu_o.addr <= a;
    cpu_o.rw <= rw;
    cpu_o.data <= v;
    repeat (2 * half + 1) @(posedge mclk_i);
    cpu_o.addr <= 16'h1000;
    cpu_o.rw <= 1'b1;
    cpu_o.data <= ~v;
  endtask
  // Pull-ups on columns; permit jumper fitted, deny open
  always_comb
  begin
    column_o = 8'hDF;
    if (!row_n_i[3])
      column_o[2] = 1'b0;
    if (!row_n_i[9])
      column_o[4] = 1'b0;
  end
endmodule // pst_cpu_model

//--- tb_pst_top.sv
// Self-checking bench for the processor support block.
// Assumes pst_cpu_model drives the processor pins and columns.
`timescale 1ns/1ps
module tb_pst_top;
  import pst_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic status_en_n_i = 1'b1;
  logic [2:0] reg_addr_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  pst_cpu_s cpu_i;
  pst_ram_s ram_o;
  logic [7:0] wlat_data_o, column_i, reg_rdata_o, d, status_data_o;
  logic [9:0] row_n_o;
  logic [2:0] pot_sel_o, pot_mux_en_o, seen;
  logic wlat_oe_n_o, status_oe_n_o, pg0, pg1, pg2, pwr_dn_o, trig_led_o;
  logic ser_data_o, atten_stb_o, frame_clk_o, subframe_load_o, irq_n_o;
  logic [1:0] fr [4] = '{PST_FRAME_TV, PST_FRAME_2LINE, PST_FRAME_4LINE,
    2'b10};
  int fn [4] = '{256, 512, 1024, 1024};
  int errors = 0;
  int n_tests = 0;
  always #10 mclk_i = ~mclk_i;
  always @(posedge mclk_i) seen <= seen & ram_o;
  pst_top i_pst_top (.mclk_i, .rst_n_i, .cpu_i, .wlat_data_o, .wlat_oe_n_o,
    .ram_o, .status_en_n_i, .status_data_o, .status_oe_n_o, .row_n_o,
    .column_i, .pot_sel_o, .ram_page_bit_0_o(pg0), .ram_page_bit_1_o(pg1),
    .ram_page_bit_2_o(pg2), .pwr_dn_o, .pot_mux_en_o, .trig_led_o,
    .ser_data_o, .atten_stb_o, .frame_clk_o, .subframe_load_o, .irq_n_o,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o);
  pst_cpu_model i_pst_cpu_model (.mclk_i, .row_n_i(row_n_o), .cpu_o(cpu_i),
    .column_o(column_i));
  task automatic conclude();
    $display("compares %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] e,
    input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %h seen %h", s, e, g);
      errors++;
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(negedge mclk_i);
    d = reg_rdata_o;
  endtask
  task automatic bus(input logic rw, input logic [15:0] a,
    input logic [2:0] e);
    seen = 3'h7;
    i_pst_cpu_model.cycle(rw, a, 8'h5A);
    repeat (4) @(posedge mclk_i);
    chk("ram enables", 16'(e), 16'(seen));
  endtask
  // Counts phase rises from divider release to the chosen tap
  task automatic measure(input bit irq, input int e);
    logic prev;
    int k;
    int n;
    wr(REG_ROW_HI, 8'h23);
    repeat (8) @(posedge mclk_i);
    chk("held taps", 16'h2, 16'({irq_n_o, frame_clk_o}));
    @(negedge cpu_i.phase);
    wr(REG_ROW_HI, 8'h03);
    n = 0;
    prev = cpu_i.phase;
    for (k = 0; k < 40000 && (irq ? irq_n_o : !frame_clk_o); k++)
    begin
      @(posedge mclk_i);
      n += int'(cpu_i.phase && !prev);
      prev = cpu_i.phase;
    end
    if (k == 40000)
    begin
      errors++;
      conclude();
    end
    else
    begin
      chk("rises to tap", 16'(e), 16'(n));
      rd(REG_STATUS);
      chk("status tap", 16'h1,
        16'(irq ? !d[ST_IRQ_N_BIT] : d[ST_FRAME_BIT]));
    end
  endtask
  initial
  begin
    #1_800_000;
    errors++;
    conclude();
  end
  initial
  begin
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(negedge mclk_i);
    chk("reset pins", 16'h3FF, 16'(row_n_o));
    chk("reset ram", 16'hF, 16'({ram_o, wlat_oe_n_o}));
    rd(REG_ROW_HI);
    chk("row high", 16'h03, 16'(d));
    wr(3'h5, 8'hA5);
    rd(3'h5);
    chk("unmapped", 16'h00, 16'(d));
    $display("test reset done");
    wr(REG_OUT_A, 8'h4D);
    wr(REG_OUT_B, 8'h2A);
    rd(REG_OUT_A);
    chk("ctl a", 16'h4D, 16'(d));
    chk("ctl a pins", 16'h4D, 16'({pwr_dn_o, pg2, pg1, pg0, pot_sel_o}));
    chk("ctl b pins", 16'h2A, 16'({atten_stb_o, ser_data_o, trig_led_o,
      pot_mux_en_o}));
    $display("test controls done");
    wr(REG_ROW_LO, 8'hF7);
    for (int c = 0; c < 7; c++)
    begin
      wr(REG_ROW_HI, 8'(c * 4 + 3));
      repeat (4) @(posedge mclk_i);
      rd(REG_STATUS);
      chk("column", 16'(c != 2 && c != 5), 16'(d[0]));
    end
    chk("cal bits", 16'h1, 16'(d[2:1]));
    chk("rows", 16'h3F7, 16'(row_n_o));
    wr(REG_ROW_LO, 8'hFF);
    wr(REG_ROW_HI, 8'h11);
    repeat (4) @(posedge mclk_i);
    rd(REG_STATUS);
    chk("row nine", 16'h0, 16'(d[0]));
    $display("test scan done");
    @(posedge cpu_i.phase);
    @(posedge mclk_i);
    status_en_n_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    chk("status on", 16'h0, 16'(status_oe_n_o));
    chk("status byte", 16'h02, 16'(status_data_o & 8'h07));
    @(negedge cpu_i.phase);
    repeat (6) @(posedge mclk_i);
    chk("status off", 16'h1, 16'(status_oe_n_o));
    status_en_n_i <= 1'b1;
    $display("test status done");
    wr(REG_OUT_A, 8'h00);
    bus(1'b1, 16'h0000, 3'h2);
    bus(1'b1, 16'h07FF, 3'h2);
    bus(1'b1, 16'h0800, 3'h7);
    bus(1'b1, 16'h8000, 3'h7);
    bus(1'b0, 16'h0123, 3'h1);
    for (int p = 0; p < 3; p++)
    begin
      wr(REG_OUT_A, 8'(8 << p));
      bus(1'b1, 16'h9FFF, 3'h2);
    end
    bus(1'b0, 16'h8000, 3'h1);
    bus(1'b1, 16'hA000, 3'h7);
    i_pst_cpu_model.cycle(1'b0, 16'h0040, 8'hC3);
    repeat (10) @(posedge mclk_i);
    chk("latch held", 16'hC3, 16'({wlat_oe_n_o, wlat_data_o}));
    repeat (20) @(posedge mclk_i);
    chk("latch off", 16'h1, 16'(wlat_oe_n_o));
    $display("test ram done");
    i_pst_cpu_model.half = 4;
    for (int i = 0; i < 4; i++)
    begin
      wr(REG_OUT_B, {fr[i], 6'h00});
      measure(1'b0, fn[i]);
    end
    measure(1'b1, 4096);
    wr(REG_ROW_HI, 8'h23);
    repeat (8) @(posedge mclk_i);
    chk("tick withdrawn", 16'h1, 16'(irq_n_o));
    // Service order: resume the switch scan first, then analog update
    wr(REG_ROW_HI, 8'h03);
    wr(REG_OUT_B, 8'h07);
    rd(REG_OUT_B);
    chk("analog update", 16'h07, 16'(pot_mux_en_o));
    rd(REG_STATUS);
    chk("scan resumed", 16'h1, 16'(d[0]));
    $display("test divider done");
    conclude();
  end
endmodule // tb_pst_top
